// >>> design/asag_axis_acc.sv
// One-axis programmable-rate accumulator
`timescale 1ns/100ps
`include "asag_regs.svh"
module asag_axis_acc #(
   parameter int ACC_W = `ASAG_ACC_W
) (
   // Clock and reset
   input  wire logic                  mclk_in,
   input  wire logic                  rst_in,
   // Control
   input  wire logic                  load_in,
   input  wire logic                  step_in,
   input  wire asag_pkg::asag_axis_cfg_s cfg_in,
   // Result
   output logic [ACC_W-1:0]           acc_out
);
   initial begin
      if (ACC_W != `ASAG_ACC_W) $error("asag_axis_acc: width must be 16");
   end
   logic [ACC_W-1:0] start_q;
   logic [ACC_W-1:0] start_d;
   logic [ACC_W-1:0] step_q;
   logic [ACC_W-1:0] step_d;
   logic [ACC_W-1:0] acc_q;
   logic [ACC_W-1:0] acc_d;
   logic [ACC_W-1:0] opb;
   always_comb begin
      start_d = cfg_in.start;                    // RL4
      step_d  = cfg_in.step;                     // RL5
      opb     = load_in ? start_q : acc_q;       // RL6
      if (load_in) begin
         acc_d = opb;                            // RL4
      end else if (step_in) begin
         acc_d = opb + step_q;                   // RL3 RL5 RL8
      end else begin
         acc_d = acc_q;
      end
   end
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         start_q <= 16'h0000;
         step_q  <= 16'h0000;
         acc_q   <= 16'h0000;
      end else begin
         start_q <= start_d;
         step_q  <= step_d;
         acc_q   <= acc_d;
      end
   end
   assign acc_out = acc_q;
endmodule

// >>> design/asag_pkg.sv
// Types shared by the affine scan address generator
package asag_pkg;
   typedef struct packed {
      logic [15:0] start;
      logic [15:0] step;
   } asag_axis_cfg_s;
   typedef struct packed {
      logic [9:0] ix;
      logic [9:0] iy;
      logic [3:0] fx;
      logic [3:0] fy;
   } asag_coord_s;
   typedef enum logic [2:0] {
      ASAG_IDLE  = 3'b001,
      ASAG_LINE  = 3'b010,
      ASAG_HOLD  = 3'b100
   } asag_state_e;
endpackage

// >>> design/asag_regs.svh
// Constants for the affine scan address generator
`ifndef ASAG_REGS_SVH
`define ASAG_REGS_SVH
`define ASAG_ACC_W        16
`define ASAG_INT_W        10
`define ASAG_FRAC_W       4
`define ASAG_ADDR_W       14
`define ASAG_DROP_W       2
`define ASAG_LINE_PIX     10'h3FF
`define ASAG_LINE_CNT     10'h3FF
`define ASAG_IMG_MAX      10'h3FF
`define ASAG_RATE_KHZ     14300
`define ASAG_CLK_KHZ      200000
`endif

// >>> design/asag_top.sv
// Affine scan address generator: display counter and coordinate transformer
`timescale 1ns/100ps
`include "asag_regs.svh"
// Overview of operation
// RL1: Scan output left-right, then top-bottom.
// RL2: Output address is x,y from upper left.
// RL3: Next coordinate is previous plus step.
// RL4: Start register loads accumulator at line start.
// RL5: Step register added every cycle; the code adds it only in cycles where a pixel is shown (valid_q).
// RL6: Accumulator output fed back as operand.
// RL7: Coordinate is 10 integer, 4 fraction bits.
// RL8: 16-bit accumulators, top 14 bits used.
// RL9: Blank pixels mapping outside input image.
// RL10: Controller loads line start values.
// RL11: Between-pixel samples are bilinearly interpolated.
// RL12: One pixel per cycle at video rate.
// RL13: Address generation shared by both halves.
// RL14: Integer parts address store, fractions weight.
// RL15: Controller updates values before line starts.
module asag_top #(
   parameter logic [9:0] LINE_PIX = `ASAG_LINE_PIX,
   parameter logic [9:0] LINE_CNT = `ASAG_LINE_CNT,
   parameter logic [9:0] IMG_W    = `ASAG_IMG_MAX,
   parameter logic [9:0] IMG_H    = `ASAG_IMG_MAX
) (
   // Clock and reset
   input  wire logic                     mclk_in,
   input  wire logic                     rst_in,
   // Frame control
   input  wire logic                     run_in,
   input  wire logic                     line_go_in,
   input  wire asag_pkg::asag_axis_cfg_s x_cfg_in,
   input  wire asag_pkg::asag_axis_cfg_s y_cfg_in,
   // Display address
   output logic [9:0]                    disp_x_out,
   output logic [9:0]                    disp_y_out,
   output logic                          disp_valid_out,
   // Input-image sample address and scan status
   output asag_pkg::asag_coord_s         coord_out,
   output logic                          blank_out,
   output logic                          line_wait_out,
   output logic                          frame_done_out
);
   initial begin
      if (LINE_PIX == 10'h000 || LINE_CNT == 10'h000) $error("asag_top: empty scan");
      if (`ASAG_CLK_KHZ < `ASAG_RATE_KHZ) $error("asag_top: clock below pixel rate");
   end

   asag_pkg::asag_state_e state_q;
   asag_pkg::asag_state_e state_d;
   logic [9:0]            px_q;
   logic [9:0]            px_d;
   logic [9:0]            ln_q;
   logic [9:0]            ln_d;
   logic                  load;
   logic                  step;
   logic                  valid_q;
   logic                  valid_d;
   logic                  done_q;
   logic                  done_d;
   logic [15:0]           xacc;
   logic [15:0]           yacc;

   function automatic logic inside_img(input logic [15:0] a, input logic [9:0] lim);
      inside_img = (a[`ASAG_ACC_W-1:`ASAG_DROP_W+`ASAG_FRAC_W] <= lim);
   endfunction

   // Scan sequencer: one line per start request, one pixel per clock
   always_comb begin
      state_d = state_q;
      px_d    = px_q;
      ln_d    = ln_q;
      load    = 1'b0;
      // Step only while a pixel is shown, so pixel 0 samples the start value
      step    = valid_q;                         // RL5
      valid_d = 1'b0;
      done_d  = 1'b0;
      unique case (state_q)
         asag_pkg::ASAG_IDLE: begin
            px_d = 10'h000;
            ln_d = 10'h000;
            if (run_in) begin
               state_d = asag_pkg::ASAG_HOLD;
            end
         end
         asag_pkg::ASAG_HOLD: begin
            if (line_go_in) begin                // RL10 RL15
               load    = 1'b1;                   // RL4
               px_d    = 10'h000;
               state_d = asag_pkg::ASAG_LINE;
            end
         end
         asag_pkg::ASAG_LINE: begin
            valid_d = 1'b1;                      // RL12
            if (px_q == LINE_PIX) begin          // RL1
               if (ln_q == LINE_CNT) begin
                  done_d  = 1'b1;
                  state_d = asag_pkg::ASAG_IDLE;
               end else begin
                  ln_d    = ln_q + 10'h001;
                  state_d = asag_pkg::ASAG_HOLD;
               end
            end else begin
               px_d = px_q + 10'h001;
            end
         end
         default: begin
            state_d = asag_pkg::ASAG_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= asag_pkg::ASAG_IDLE;
         px_q    <= 10'h000;
         ln_q    <= 10'h000;
         valid_q <= 1'b0;
         done_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         px_q    <= px_d;
         ln_q    <= ln_d;
         valid_q <= valid_d;
         done_q  <= done_d;
      end
   end

   // Display address registered alongside the accumulator step
   logic [9:0] dx_q;
   logic [9:0] dx_d;
   logic [9:0] dy_q;
   logic [9:0] dy_d;
   always_comb begin
      dx_d = px_q;                               // RL2
      dy_d = ln_q;                               // RL2
   end
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         dx_q <= 10'h000;
         dy_q <= 10'h000;
      end else begin
         dx_q <= dx_d;
         dy_q <= dy_d;
      end
   end

   // One accumulator per axis, shared by both channel halves
   asag_axis_acc #(.ACC_W(`ASAG_ACC_W)) u_xacc (  // RL13
      .mclk_in (mclk_in),
      .rst_in  (rst_in),
      .load_in (load),
      .step_in (step),
      .cfg_in  (x_cfg_in),
      .acc_out (xacc)
   );
   asag_axis_acc #(.ACC_W(`ASAG_ACC_W)) u_yacc (
      .mclk_in (mclk_in),
      .rst_in  (rst_in),
      .load_in (load),
      .step_in (step),
      .cfg_in  (y_cfg_in),
      .acc_out (yacc)
   );

   // Coordinate and blanking, registered
   asag_pkg::asag_coord_s coord_q;
   asag_pkg::asag_coord_s coord_d;
   logic                  blank_q;
   logic                  blank_d;
   always_comb begin
      coord_d    = coord_q;
      blank_d    = 1'b1;
      if (valid_q) begin
         coord_d.ix = xacc[`ASAG_ACC_W-1:`ASAG_DROP_W+`ASAG_FRAC_W]; // RL7 RL8 RL14
         coord_d.fx = xacc[`ASAG_DROP_W+`ASAG_FRAC_W-1:`ASAG_DROP_W]; // RL11
         coord_d.iy = yacc[`ASAG_ACC_W-1:`ASAG_DROP_W+`ASAG_FRAC_W]; // RL14
         coord_d.fy = yacc[`ASAG_DROP_W+`ASAG_FRAC_W-1:`ASAG_DROP_W]; // RL11
         blank_d    = !(inside_img(xacc, IMG_W) && inside_img(yacc, IMG_H)); // RL9
      end
   end
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         coord_q <= '0;
         blank_q <= 1'b1;
      end else begin
         coord_q <= coord_d;
         blank_q <= blank_d;
      end
   end

   logic dvalid_q;
   logic ddone_q;
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         dvalid_q <= 1'b0;
         ddone_q  <= 1'b0;
      end else begin
         dvalid_q <= valid_q;
         ddone_q  <= done_q;
      end
   end

   assign disp_x_out     = dx_q;
   assign disp_y_out     = dy_q;
   assign disp_valid_out = valid_q;
   assign coord_out      = coord_q;
   assign blank_out      = blank_q | ~dvalid_q;
   assign line_wait_out  = (state_q == asag_pkg::ASAG_HOLD);
   assign frame_done_out = ddone_q;
endmodule

// >>> tb/asag_store_model.sv
// Frame store read model: counts unblanked reads from the sample address stream and keeps the last address
`timescale 1ns/100ps
module asag_store_model (
   // Clock and reset
   input  wire logic                  mclk_in,
   input  wire logic                  rst_in,
   // Sample address
   input  wire asag_pkg::asag_coord_s coord_in,
   input  wire logic                  blank_in,
   // Reads taken
   output int                         hits_out,
   output asag_pkg::asag_coord_s      last_out
);
   always @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         hits_out <= 0;
         last_out <= '0;
      end else if (!blank_in) begin
         hits_out <= hits_out + 1;
         last_out <= coord_in;
      end
   end
endmodule

// >>> tb/asag_top_bench.sv
// Self-checking bench for the affine scan address generator
`timescale 1ns/100ps
module asag_top_bench;
   logic                     mclk_in    = 1'b0;
   logic                     rst_in     = 1'b1;
   logic                     run_in     = 1'b0;
   logic                     line_go_in = 1'b0;
   asag_pkg::asag_axis_cfg_s x_cfg_in   = '0;
   asag_pkg::asag_axis_cfg_s y_cfg_in   = '0;
   logic [9:0]               disp_x_out;
   logic [9:0]               disp_y_out;
   logic                     disp_valid_out;
   asag_pkg::asag_coord_s    coord_out;
   logic                     blank_out;
   logic                     line_wait_out;
   logic                     frame_done_out;
   int                       hits;
   asag_pkg::asag_coord_s    last;
   asag_pkg::asag_coord_s    last_ec    = '0;
   int                       n_errors   = 0;
   int                       n_tests    = 0;
   int                       cyc        = 0;
   int                       exp_hits   = 0;
   always #2.5 mclk_in = ~mclk_in;
   asag_top #(.LINE_PIX(10'h003), .LINE_CNT(10'h001), .IMG_W(10'h005), .IMG_H(10'h005)) uut (.*);
   asag_store_model u_store (.mclk_in(mclk_in), .rst_in(rst_in), .coord_in(coord_out),
      .blank_in(blank_out), .hits_out(hits), .last_out(last));
   task test_done;
      if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task wait_for(input logic sel);
      int i;
      i = 0;
      while ((sel ? disp_valid_out : line_wait_out) !== 1'b1 && i < 20) begin
         @(negedge mclk_in);
         i++;
      end
   endtask
   // Two lines of four pixels; lvl holds line_go_in high all frame
   task frame(input logic [15:0] xs, xd, xl, ys, yd, yl, input logic lvl);
      logic [15:0] ax;
      logic [15:0] ay;
      asag_pkg::asag_coord_s ec;
      x_cfg_in.step = xd;
      y_cfg_in.step = yd;
      run_in = 1'b1;
      for (int l = 0; l < 2; l++) begin
         x_cfg_in.start = xs + 16'(l * xl);
         y_cfg_in.start = ys + 16'(l * yl);
         if (!lvl) begin
            repeat (2) @(negedge mclk_in);
            wait_for(1'b0);
            chk("line_wait", line_wait_out, 1'b1);
         end
         line_go_in = 1'b1;
         wait_for(1'b1);
         run_in = 1'b0;
         line_go_in = lvl;
         for (int n = 0; n < 4; n++) begin
            chk("disp_x", disp_x_out, 32'(n));
            chk("disp_y", disp_y_out, 32'(l));
            ax = x_cfg_in.start + 16'(n * xd);
            ay = y_cfg_in.start + 16'(n * yd);
            ec = {ax[15:6], ay[15:6], ax[5:2], ay[5:2]};
            @(negedge mclk_in);
            chk("coord", coord_out, ec);
            chk("blank", blank_out, ec.ix > 10'h005 || ec.iy > 10'h005);
            chk("frame_done", frame_done_out, n == 3 && l == 1);
            if (ec.ix <= 10'h005 && ec.iy <= 10'h005) begin
               exp_hits++;
               last_ec = ec;
            end
         end
         chk("line_end", disp_valid_out, 1'b0);
      end
      line_go_in = 1'b0;
      repeat (3) @(negedge mclk_in);
      chk("hits", hits, exp_hits);
      chk("last", last, last_ec);
   endtask
   task t_unity;
      frame(16'h0000, 16'h0040, 16'h0000, 16'h0000, 16'h0000, 16'h0040, 1'b0);
   endtask
   task t_shrink_shift;
      frame(16'h0100, 16'h0080, 16'h0040, 16'h0100, 16'h0000, 16'h0040, 1'b0);
   endtask
   task t_rotate_level;
      frame(16'h0000, 16'h0019, 16'h0000, 16'h0150, 16'hFFE8, 16'h0000, 1'b1);
   endtask
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         test_done();
      end
   end
   initial begin
      repeat (3) @(negedge mclk_in);
      rst_in = 1'b0;
      chk("idle_blank", blank_out, 1'b1);
      t_unity();
      t_shrink_shift();
      t_rotate_level();
      test_done();
   end
endmodule

// >>> tb/asag_top_chk.sv
// Port assertions for the affine scan address generator
`timescale 1ns/100ps
module asag_top_chk #(
   parameter logic [9:0] LINE_PIX = 10'h3FF,
   parameter logic [9:0] IMG_W    = 10'h3FF,
   parameter logic [9:0] IMG_H    = 10'h3FF
) (
   // Block inputs
   input wire logic                     mclk_in,
   input wire logic                     rst_in,
   input wire logic                     line_go_in,
   input wire asag_pkg::asag_axis_cfg_s x_cfg_in,
   input wire asag_pkg::asag_axis_cfg_s y_cfg_in,
   // Block outputs
   input wire logic [9:0]               disp_x_out,
   input wire logic                     disp_valid_out,
   input wire asag_pkg::asag_coord_s    coord_out,
   input wire logic                     blank_out,
   input wire logic                     line_wait_out,
   input wire logic                     frame_done_out
);
   wire logic [13:0] cx = {coord_out.ix, coord_out.fx};
   wire logic [13:0] cy = {coord_out.iy, coord_out.fy};
   default clocking @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);
   a_first_x: assert property ($rose(disp_valid_out) |-> disp_x_out == 10'h000)
      else $error("first x");
   a_x_order: assert property (disp_valid_out && disp_x_out != 10'h000 |->
      disp_x_out == $past(disp_x_out) + 10'h001) else $error("x order");
   a_line_end: assert property (disp_valid_out && disp_x_out == LINE_PIX |=>
      !disp_valid_out) else $error("line end");
   // Guard bits may carry one into the visible part
   a_acc_step: assert property ($past(disp_valid_out) && $past(disp_x_out) != 10'h000 |->
      14'(cx - $past(cx) - x_cfg_in.step[15:2]) <= 14'h0001 &&
      14'(cy - $past(cy) - y_cfg_in.step[15:2]) <= 14'h0001) else $error("step");
   a_line_load: assert property ($past(disp_valid_out) && !$past(disp_valid_out, 2) |->
      cx == x_cfg_in.start[15:2] && cy == y_cfg_in.start[15:2]) else $error("start");
   a_blank_range: assert property ($past(disp_valid_out) |->
      blank_out == (coord_out.ix > IMG_W || coord_out.iy > IMG_H)) else $error("range");
   a_blank_idle: assert property (!$past(disp_valid_out) |-> blank_out)
      else $error("idle");
   a_go_taken: assert property (line_wait_out && line_go_in |=>
      ##1 disp_valid_out && disp_x_out == 10'h000) else $error("go");
   a_done_pulse: assert property (frame_done_out |=> !frame_done_out)
      else $error("done");
   c_go: cover property (line_wait_out && line_go_in);
   c_blank: cover property ($past(disp_valid_out) && blank_out);
   c_done: cover property (frame_done_out);
endmodule
bind asag_top asag_top_chk #(.LINE_PIX(LINE_PIX), .IMG_W(IMG_W), .IMG_H(IMG_H)) u_chk (.*);
